// ===== rtl/system_clock_source_select.sv
// Notes on behaviour
// RL1 - four sources: two fast, two slow
// RL2 - internal fast rc runs 8, 12 or 16 MHz
// RL3 - slow select bit picks slow source
// RL4 - fast select bit picks fast source
// RL5 - ratio field sets system clock rate, source
// RL6 - firmware may switch clocks at run time
// RL7 - external fast crystal chosen after reset
// RL8 - one fast, one slow source always selected
// RL9 - oscillators also clock watchdog and time base
// RL10 - internal fast rc selected frees fast crystal pins
// RL11 - codes 0..6 divide fast by 2^n; 7 slow
// RL12 - slow clock from either slow source
// RL13 - switching never makes runt clock pulses
// RL14 - changes applied at clock boundary, or when the stall counter expires
`include "sysclk_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module system_clock_source_select
  import sysclk_pkg::*;
#(
  parameter int STALL_CYCLES = `STALL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ext_fast_crystal,
  input wire logic int_fast_rc,
  input wire logic ext_slow_crystal,
  input wire logic int_slow_rc,
  input wire logic fast_source_sel,
  input wire logic slow_source_sel,
  input wire logic [2:0] sysclk_ratio_sel,
  input wire logic [1:0] int_fast_rc_freq_sel,
  input wire logic timebase_source_sel,
  output logic sysclk_en,
  output logic fast_clk_en,
  output logic slow_clk_en,
  output logic wdt_clk_en,
  output logic timebase_clk_en,
  output logic sysclk_is_slow,
  output logic fast_source_active,
  output logic slow_source_active,
  output logic [2:0] sysclk_ratio_active,
  output logic [1:0] int_fast_rc_freq_code,
  output logic fast_xtal_pins_free
);

  // =====================================================
  // elaboration check
  if (STALL_CYCLES < 1 || STALL_CYCLES >= (1 << `STALL_CNT_WIDTH)) begin : g_bad_stall
    $error("STALL_CYCLES out of range");
  end

  localparam logic [15:0] STALL_LIMIT = 16'(STALL_CYCLES - 1);

  clk_state_type state_reg;
  clk_state_type state_next;

  logic [3:0] osc_pins;
  logic [3:0] osc_edge;
  logic fast_edge;
  logic slow_edge;
  logic [5:0] div_mask;
  logic fast_div_tick;
  logic sys_tick;
  logic apply_now;

  // =====================================================
  // oscillator inputs, one channel per source
  assign osc_pins = {int_slow_rc, ext_slow_crystal, int_fast_rc, ext_fast_crystal}; // RL1

  // =====================================================
  // next state
  always_comb begin
    state_next = state_reg;
    // two-stage synchronisers, then rising edge detect
    state_next.sync1 = osc_pins;
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;
    for (int i = 0; i < OSC_COUNT; i++) begin
      osc_edge[i] = state_reg.sync2[i] & ~state_reg.prev[i];
    end
    // exactly one source per path, never none
    fast_edge = state_reg.fast_sel ? osc_edge[osc_int_fast_rc] : osc_edge[osc_ext_fast_crystal]; // RL4 RL8
    slow_edge = state_reg.slow_sel ? osc_edge[osc_int_slow_rc] : osc_edge[osc_ext_slow_crystal]; // RL3 RL8 RL12
    // divide by 2^ratio on fast edges
    div_mask = 6'((7'h01 << state_reg.ratio) - 7'h01); // RL11
    fast_div_tick = fast_edge && ((state_reg.fast_div & div_mask) == div_mask);
    sys_tick = (state_reg.ratio == `RATIO_SLOW_CODE) ? slow_edge : fast_div_tick; // RL5 RL11
    // settings taken at a system clock boundary, or if the source is dead
    apply_now = sys_tick || (state_reg.stall_cnt == STALL_LIMIT); // RL14 RL13
    if (fast_edge) begin
      state_next.fast_div = state_reg.fast_div + 6'h01;
    end
    if (sys_tick || apply_now) begin
      state_next.stall_cnt = 16'h0000;
    end else begin
      state_next.stall_cnt = state_reg.stall_cnt + 16'h0001;
    end
    if (apply_now) begin
      // run-time switch without reset
      state_next.fast_sel = fast_source_sel; // RL6
      state_next.slow_sel = slow_source_sel; // RL6
      state_next.ratio = sysclk_ratio_sel; // RL6
      // restart divider so the first divided period is whole
      state_next.fast_div = 6'h00; // RL13
    end
    // internal rc trim code: reserved code keeps old setting
    if (int_fast_rc_freq_sel == `RC_FREQ_8MHZ || int_fast_rc_freq_sel == `RC_FREQ_12MHZ
        || int_fast_rc_freq_sel == `RC_FREQ_16MHZ) begin
      state_next.rc_freq = int_fast_rc_freq_sel; // RL2
    end
    // one-cycle enables only, so no runt pulses can appear
    state_next.sysclk_en = sys_tick; // RL13
    state_next.fast_en = fast_edge;
    state_next.slow_en = slow_edge;
    state_next.timebase_en = timebase_source_sel ? fast_edge : slow_edge; // RL9
    if (!rst_b) begin
      state_next = '0;
      state_next.fast_sel = `FAST_SEL_RESET; // RL7
      state_next.slow_sel = `SLOW_SEL_RESET;
      state_next.ratio = `RATIO_RESET;
      state_next.rc_freq = `RC_FREQ_RESET;
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // =====================================================
  // outputs
  assign sysclk_en = state_reg.sysclk_en;
  assign fast_clk_en = state_reg.fast_en;
  assign slow_clk_en = state_reg.slow_en;
  assign wdt_clk_en = state_reg.slow_en; // RL9
  assign timebase_clk_en = state_reg.timebase_en; // RL9
  assign sysclk_is_slow = (state_reg.ratio == `RATIO_SLOW_CODE); // RL5
  assign fast_source_active = state_reg.fast_sel;
  assign slow_source_active = state_reg.slow_sel;
  assign sysclk_ratio_active = state_reg.ratio;
  assign int_fast_rc_freq_code = state_reg.rc_freq; // RL2
  assign fast_xtal_pins_free = (state_reg.fast_sel == `FAST_SEL_INT_RC); // RL10

endmodule

`default_nettype wire

// ===== rtl/sysclk_defs.svh
`ifndef SYSCLK_DEFS_SVH
`define SYSCLK_DEFS_SVH

// =====================================================
// source select encodings
`define FAST_SEL_EXT_CRYSTAL 1'b0
`define FAST_SEL_INT_RC 1'b1
`define SLOW_SEL_EXT_CRYSTAL 1'b0
`define SLOW_SEL_INT_RC 1'b1

// =====================================================
// ratio field
`define RATIO_WIDTH 3
`define RATIO_SLOW_CODE 3'h7
`define FAST_DIV_WIDTH 6

// =====================================================
// reset values
`define FAST_SEL_RESET `FAST_SEL_EXT_CRYSTAL
`define SLOW_SEL_RESET `SLOW_SEL_EXT_CRYSTAL
`define RATIO_RESET 3'h0
`define RC_FREQ_RESET 2'h0

// =====================================================
// internal fast rc frequency codes
`define RC_FREQ_8MHZ 2'h0
`define RC_FREQ_12MHZ 2'h1
`define RC_FREQ_16MHZ 2'h2

// =====================================================
// timing
`define CLK_PERIOD_NS 10
`define STALL_TIME_NS 40960
`define STALL_CYCLES (`STALL_TIME_NS / `CLK_PERIOD_NS)
`define STALL_CNT_WIDTH 16

`endif

// ===== rtl/sysclk_pkg.sv
package sysclk_pkg;

  // =====================================================
  // oscillator channels
  typedef enum {
    osc_ext_fast_crystal,
    osc_int_fast_rc,
    osc_ext_slow_crystal,
    osc_int_slow_rc
  } osc_index_type;

  localparam int OSC_COUNT = 4;

  // =====================================================
  // whole block state
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic fast_sel;
    logic slow_sel;
    logic [2:0] ratio;
    logic [1:0] rc_freq;
    logic [5:0] fast_div;
    logic [15:0] stall_cnt;
    logic sysclk_en;
    logic fast_en;
    logic slow_en;
    logic timebase_en;
  } clk_state_type;

endpackage

// ===== bench/sysclk_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sysclk_chk #(parameter int STALL_CYCLES = 16) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] int_fast_rc_freq_sel,
  input wire logic sysclk_en,
  input wire logic fast_clk_en,
  input wire logic slow_clk_en,
  input wire logic wdt_clk_en,
  input wire logic sysclk_is_slow,
  input wire logic fast_source_active,
  input wire logic [2:0] sysclk_ratio_active,
  input wire logic [1:0] int_fast_rc_freq_code,
  input wire logic fast_xtal_pins_free,
  input wire logic timebase_source_sel,
  input wire logic timebase_clk_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  int gap;
  always_ff @(posedge clk) gap <= (!rst_b || sysclk_en) ? 0 : gap + 1;
  property p_div; $stable(sysclk_ratio_active) && sysclk_ratio_active == 3'h0 |-> sysclk_en == fast_clk_en; endproperty
  a_div: assert property (p_div) else $error("fast tick");
  property p_slw; $stable(sysclk_ratio_active) && sysclk_ratio_active == 3'h7 |-> sysclk_en == slow_clk_en; endproperty
  a_slw: assert property (p_slw) else $error("slow tick");
  property p_is; sysclk_is_slow == (sysclk_ratio_active == 3'h7); endproperty
  a_is: assert property (p_is) else $error("slow flag");
  property p_pin; fast_xtal_pins_free == fast_source_active; endproperty
  a_pin: assert property (p_pin) else $error("pins");
  property p_wdt; wdt_clk_en == slow_clk_en; endproperty
  a_wdt: assert property (p_wdt) else $error("wdt tick");
  property p_one; sysclk_en |=> !sysclk_en; endproperty
  a_one: assert property (p_one) else $error("runt");
  property p_app; !$stable(sysclk_ratio_active) |-> sysclk_en || gap >= STALL_CYCLES - 2; endproperty
  a_app: assert property (p_app) else $error("apply");
  property p_rc; int_fast_rc_freq_sel != 2'h3 |=> int_fast_rc_freq_code == $past(int_fast_rc_freq_sel); endproperty
  a_rc: assert property (p_rc) else $error("rc code");
  property p_tb; timebase_clk_en == ($past(timebase_source_sel) ? fast_clk_en : slow_clk_en); endproperty
  a_tb: assert property (p_tb) else $error("time base tick");
endmodule
bind system_clock_source_select sysclk_chk #(.STALL_CYCLES(STALL_CYCLES)) sysclk_chk_i (.*);
`default_nettype wire

// ===== bench/tb_system_clock_source_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_source_select;
  logic clk = 0, rst_b = 0, ext_fast_crystal = 0, int_fast_rc = 0, ext_slow_crystal = 0, int_slow_rc = 0;
  logic fast_source_sel = 0, slow_source_sel = 0, timebase_source_sel = 0;
  logic [2:0] sysclk_ratio_sel = 0, sysclk_ratio_active;
  logic [1:0] int_fast_rc_freq_sel = 0, int_fast_rc_freq_code;
  logic sysclk_en, fast_clk_en, slow_clk_en, wdt_clk_en, timebase_clk_en, sysclk_is_slow;
  logic fast_source_active, slow_source_active, fast_xtal_pins_free;
  int errors = 0, n_checks = 0, k = 0, n, m, t;
  system_clock_source_select #(.STALL_CYCLES(2000)) system_clock_source_select_i (.*);
  always #5 clk = ~clk;
  // =====================================================
  // oscillators
  always @(negedge clk) begin
    k <= k + 1;
    ext_fast_crystal <= k % 4 < 2;
    int_fast_rc <= k % 6 < 3;
    ext_slow_crystal <= k % 14 < 7;
    int_slow_rc <= k % 22 < 11;
  end
  task chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function int edges(input logic [2:0] r);
    return r == 3'h7 ? 2 : 2 << r;
  endfunction
  // =====================================================
  // every code, then random
  initial begin
    t = $urandom(33);
    repeat (20) @(negedge clk);
    rst_b = 1;
    @(negedge clk);
    chk(fast_source_active, 0);
    for (int i = 0; i < 14; i++) begin
      {fast_source_sel, slow_source_sel, timebase_source_sel, int_fast_rc_freq_sel} = 5'($urandom);
      sysclk_ratio_sel = sysclk_ratio_sel + 3'(i < 8 ? 1 : 1 + $urandom % 7);
      t = 0;
      while ({fast_source_active, slow_source_active, sysclk_ratio_active} !==
             {fast_source_sel, slow_source_sel, sysclk_ratio_sel}) begin
        @(negedge clk);
        t++;
        if (t > 3000) begin
          errors++;
          summarize;
        end
      end
      chk(fast_xtal_pins_free, fast_source_sel);
      chk(slow_source_active, slow_source_sel);
      n = 0;
      m = 0;
      while (n < edges(sysclk_ratio_sel) && t < 6000) begin
        @(posedge clk);
        #1;
        n += sysclk_ratio_sel == 3'h7 ? slow_clk_en : fast_clk_en;
        m += sysclk_en;
        t++;
      end
      chk(4'(m), 4'h2);
      @(negedge clk);
    end
    summarize;
  end
endmodule
`default_nettype wire
